/* rmmp_mac_port.sv */
`timescale 1ns/1ps
// Function
// - sample speed strap at reset events; high means 100 Mbps, low 10 Mbps.
// - drive received nibble, changing on falling edge of generated receive clock.
// - raise receive valid, synchronous to receive clock, while nibble carries frame data.
// - raise receive error, synchronous to receive clock, while presented nibble is invalid.
// - make transmit and receive clocks from 25 MHz reference: 2.5 or 25 MHz.
// - at 100 Mbps with transmit error, send invalid code symbols instead of data.
// - capture transmit nibble on transmit clock rise when enable high, else ignore.
// - drive collision high toward MAC while the segment has a collision.
// - carrier sense high while transmitting or receiving through this port, else low.
module rmmp_mac_port (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              clkEn,
  input  wire logic              swReset,          // software reset pulse from repeater core
  input  wire logic              port_speed_strap,
  input  wire logic              ref_clock_25mhz,  // sampled like any pin
  output logic                   rx_port_clock,
  output logic                   tx_port_clock,
  output rmmp_pkg::rmmp_rx_t     rxOut,            // nibble, valid, error toward MAC
  input  wire logic              tx_frame_enable,
  input  wire logic [3:0]        txNibbleIn,
  input  wire logic              tx_stream_error,
  input  wire rmmp_pkg::rmmp_rx_t rxIn,            // from repeater core
  output logic                   rxInReady,
  output rmmp_pkg::rmmp_tx_t     txOut,            // toward repeater core
  output logic                   txOutValid,
  input  wire logic              txOutReady,
  input  wire logic              repCollision,
  input  wire logic              repReceiving,
  output logic                   segment_collision,
  output logic                   port_carrier_sense,
  output logic                   speed100
);
  // ==========================================================================
  // pin synchronisers: first stage is read only by second stage
  logic [2:0] syncA_q, syncB_q;
  logic [3:0] txdA_q, txdB_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
      txdA_q  <= 4'h0;
      txdB_q  <= 4'h0;
    end else if (clkEn) begin
      syncA_q <= {ref_clock_25mhz, tx_frame_enable, tx_stream_error};
      syncB_q <= syncA_q;
      txdA_q  <= txNibbleIn;
      txdB_q  <= txdA_q;
    end
  end
  logic refS, txEnS, txErrS;
  assign {refS, txEnS, txErrS} = syncB_q;

  // ==========================================================================
  // speed strap: sample once after reset release or soft reset, then hold
  rmmp_pkg::rmmp_spd_state_t spdState_q;
  logic strapA_q, strapB_q, speed_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapA_q <= 1'b0;
      strapB_q <= 1'b0;
    end else if (clkEn) begin
      strapA_q <= port_speed_strap;
      strapB_q <= strapA_q;
    end
  end
  // sampling waits until the synchroniser holds a post-reset level
  logic [1:0] settle_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spdState_q <= rmmp_pkg::RMMP_SPD_SAMPLE;
      settle_q   <= 2'h0;
      speed_q    <= rmmp_pkg::SPEED_10_LVL;
    end else if (clkEn) begin
      case (spdState_q)
        rmmp_pkg::RMMP_SPD_SAMPLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == 2'h3) begin
            speed_q    <= (strapB_q == rmmp_pkg::SPEED_100_LVL);
            spdState_q <= rmmp_pkg::RMMP_SPD_HOLD;
          end
        end
        rmmp_pkg::RMMP_SPD_HOLD: begin
          if (swReset) begin
            spdState_q <= rmmp_pkg::RMMP_SPD_SAMPLE;
            settle_q   <= 2'h0;
          end
        end
        default: spdState_q <= rmmp_pkg::RMMP_SPD_SAMPLE;
      endcase
    end
  end
  assign speed100 = speed_q;

  // ==========================================================================
  // port clock divider on sampled reference edges: rising only at 10 Mbps, both at 100 Mbps
  logic refD_q;
  logic [rmmp_pkg::DIV_W-1:0] divCnt_q;
  logic portClk_q, portRise, portFall;
  wire refRise = refS & ~refD_q;
  wire refEdge = refS ^ refD_q;
  // fast mode steps on both reference edges, so the port clock runs at the reference rate
  wire refStep = speed_q ? refEdge : refRise;
  wire [rmmp_pkg::DIV_W-1:0] halfCnt = speed_q ? rmmp_pkg::HALF_100 : rmmp_pkg::HALF_10;
  wire toggle = refStep && (divCnt_q >= halfCnt);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refD_q    <= 1'b0;
      divCnt_q  <= '0;
      portClk_q <= 1'b0;
    end else if (clkEn) begin
      refD_q <= refS;
      if (refStep) begin
        divCnt_q <= toggle ? '0 : divCnt_q + 1'b1;
      end
      if (toggle) begin
        portClk_q <= ~portClk_q;
      end
    end
  end
  // at 100 Mbps the port clock flips on each reference edge: same rate as the reference
  // at 10 Mbps it flips every fifth reference rise: one tenth of the reference rate
  assign portRise = toggle & ~portClk_q;
  assign portFall = toggle & portClk_q;
  assign rx_port_clock = portClk_q;
  assign tx_port_clock = portClk_q;

  // ==========================================================================
  // receive path: two-entry buffer, drained one nibble per port clock fall
  rmmp_pkg::rmmp_rx_t rxBuf_q [2];
  logic [1:0] rxCnt_q;
  logic rxRd_q, rxWr_q;
  wire rxPush = rxInReady && rxIn.valid;
  wire rxPop  = portFall && (rxCnt_q != 2'h0);
  assign rxInReady = (rxCnt_q != 2'h2);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxCnt_q <= 2'h0;
      rxRd_q  <= 1'b0;
      rxWr_q  <= 1'b0;
      rxBuf_q[0] <= '0;
      rxBuf_q[1] <= '0;
    end else if (clkEn) begin
      if (rxPush) begin
        rxBuf_q[rxWr_q] <= rxIn;
        rxWr_q <= ~rxWr_q;
      end
      if (rxPop) rxRd_q <= ~rxRd_q;
      rxCnt_q <= rxCnt_q + {1'b0, rxPush} - {1'b0, rxPop};
    end
  end
  // outputs change only on falling port clock, so the MAC samples stable data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxOut <= '0;
    end else if (clkEn && portFall) begin
      if (rxCnt_q != 2'h0) begin
        rxOut.nibble <= rxBuf_q[rxRd_q].nibble;
        rxOut.valid  <= 1'b1;
        rxOut.error  <= rxBuf_q[rxRd_q].error;
      end else begin
        rxOut <= '0;
      end
    end
  end

  // ==========================================================================
  // transmit path: capture on port clock rise while enable high
  rmmp_pkg::rmmp_tx_t txBuf_q [2];
  logic [1:0] txCnt_q;
  logic txRd_q, txWr_q;
  // a tied-low enable never captures anything
  wire txPush = portRise && txEnS && (txCnt_q != 2'h2);
  wire txPop  = txOutValid && txOutReady;
  assign txOutValid = (txCnt_q != 2'h0);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txCnt_q <= 2'h0;
      txRd_q  <= 1'b0;
      txWr_q  <= 1'b0;
      txBuf_q[0] <= '0;
      txBuf_q[1] <= '0;
    end else if (clkEn) begin
      if (txPush) begin
        // error only honoured at 100 Mbps; replaces the nibble
        if (speed_q && txErrS) begin
          txBuf_q[txWr_q] <= '{nibble: rmmp_pkg::BAD_SYMBOL_NIBBLE, error: 1'b1};
        end else begin
          txBuf_q[txWr_q] <= '{nibble: txdB_q, error: 1'b0};
        end
        txWr_q <= ~txWr_q;
      end
      if (txPop) txRd_q <= ~txRd_q;
      txCnt_q <= txCnt_q + {1'b0, txPush} - {1'b0, txPop};
    end
  end
  assign txOut = txBuf_q[txRd_q];

  // ==========================================================================
  // status toward MAC
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      segment_collision  <= 1'b0;
      port_carrier_sense <= 1'b0;
    end else if (clkEn) begin
      segment_collision  <= repCollision;
      port_carrier_sense <= repReceiving | txEnS | rxOut.valid;
    end
  end

  // ==========================================================================
  AST_RX_FALL: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && !portFall |=> $stable(rxOut.nibble)) else $error("rx nibble moved off falling edge");
  AST_RX_VALID: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && portFall && rxCnt_q != 2'h0 |=> rxOut.valid) else $error("rx valid missing");
  AST_RX_ERR: assert property (@(posedge clk) disable iff (!arst_n)
    rxOut.error |-> rxOut.valid) else $error("rx error without valid");
  AST_CLK_EQ: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && speed_q && refEdge |=> $changed(tx_port_clock) && rx_port_clock == tx_port_clock)
    else $error("port clock does not follow reference at 100 Mbps");
  AST_TX_ERR: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && txPush && !speed_q |=> !txBuf_q[$past(txWr_q)].error) else $error("tx error at 10 Mbps");
  AST_TX_IGN: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && !txEnS && !txPop |=> txCnt_q == $past(txCnt_q)) else $error("tx captured without enable");
  AST_SPD_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    spdState_q == rmmp_pkg::RMMP_SPD_HOLD && !swReset |=> $stable(speed_q)) else $error("speed changed");
  AST_COL: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && repCollision |=> segment_collision) else $error("collision not shown");
  AST_CRS: assert property (@(posedge clk) disable iff (!arst_n)
    clkEn && repReceiving |=> port_carrier_sense) else $error("carrier not shown");
endmodule // rmmp_mac_port

/* rmmp_pkg.sv */
package rmmp_pkg;
  // ==========================================================================
  // speed encoding and clock division
  localparam logic SPEED_100_LVL = 1'b1;
  localparam logic SPEED_10_LVL  = 1'b0;
  localparam int   CLK_MHZ       = 125;
  localparam int   REF_MHZ       = 25;
  localparam int   DIV_100       = 1;    // port clock = ref / 1 = 25 MHz
  localparam int   DIV_10        = 10;   // port clock = ref / 10 = 2.5 MHz
  localparam int   DIV_W         = 4;
  localparam logic [DIV_W-1:0] HALF_100 = 4'h0;  // toggle on every ref edge, rise and fall
  localparam logic [DIV_W-1:0] HALF_10  = 4'h4;  // 5 ref cycles per half period
  // invalid code symbol stand-in nibble sent on a transmit error at 100 Mbps
  localparam logic [3:0] BAD_SYMBOL_NIBBLE = 4'h5;
  localparam logic [3:0] NIBBLE_RST        = 4'h0;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [3:0] nibble;
    logic       valid;
    logic       error;
  } rmmp_rx_t;

  typedef struct packed {
    logic [3:0] nibble;
    logic       error;
  } rmmp_tx_t;

  typedef enum logic [1:0] {
    RMMP_SPD_SAMPLE = 2'b00,
    RMMP_SPD_HOLD   = 2'b01
  } rmmp_spd_state_t;
endpackage

/* rmmp_mac_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// mac partner: sends queued nibbles, collects received nibbles
module rmmp_mac_model (
  input  wire logic               clk,
  input  wire logic               tx_port_clock,
  input  wire logic               rx_port_clock,
  input  wire rmmp_pkg::rmmp_rx_t rxOut,
  output logic                    tx_frame_enable,
  output logic [3:0]              txNibbleIn,
  output logic                    tx_stream_error
);
  rmmp_pkg::rmmp_tx_t txQ[$];
  rmmp_pkg::rmmp_rx_t rxQ[$];
  logic               txClkQ = 1'b0;
  logic               rxClkQ = 1'b0;
  rmmp_pkg::rmmp_tx_t t;
  initial begin
    tx_frame_enable = 1'b0;
    txNibbleIn = 4'ha;
    tx_stream_error = 1'b0;
  end
  // new nibble after each transmit clock fall, so it is steady at the rise
  always @(posedge clk) begin
    txClkQ <= tx_port_clock;
    rxClkQ <= rx_port_clock;
    if (txClkQ && !tx_port_clock) begin
      if (txQ.size() > 0) begin
        t = txQ.pop_front();
        tx_frame_enable <= 1'b1;
        txNibbleIn <= t.nibble;
        tx_stream_error <= t.error;
      end else begin
        tx_frame_enable <= 1'b0;
        txNibbleIn <= ~txNibbleIn;  // idle data toggles, never a stale copy
        tx_stream_error <= 1'b0;
      end
    end
    if (!rxClkQ && rx_port_clock && rxOut.valid) rxQ.push_back(rxOut);
  end
endmodule // rmmp_mac_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic refClk = 1'b0;
  logic swReset = 1'b0;
  logic strap = 1'b1;
  logic txOutReady = 1'b1;
  logic repCollision = 1'b0;
  logic repReceiving = 1'b0;
  rmmp_pkg::rmmp_rx_t rxIn = '0;
  rmmp_pkg::rmmp_rx_t rxOut;
  rmmp_pkg::rmmp_rx_t rxPrev = '0;
  rmmp_pkg::rmmp_tx_t txOut;
  logic rxInReady, txOutValid, rxClk, txClk, col, crs, speed100, txEn, txErr;
  logic [3:0] txNib;
  logic [31:0] seed = 32'h39;
  int errors = 0;
  int samples_checked = 0;
  int rxLeft = 0;
  int cnt[2];
  logic colLast = 1'b0;
  logic armed = 1'b0;
  logic clkPrev = 1'b0;
  logic sawFull = 1'b0;
  rmmp_pkg::rmmp_rx_t rxExp[$];
  rmmp_pkg::rmmp_tx_t txExp[$];
  // ==========================================================================
  // clocks: the reference pin is free running and unrelated in phase
  always #4 clk = ~clk;
  initial begin
    #13;
    forever #40 refClk = ~refClk;
  end
  rmmp_mac_port u_dut (.clk, .arst_n, .clkEn(1'b1), .swReset, .port_speed_strap(strap),
    .ref_clock_25mhz(refClk), .rx_port_clock(rxClk), .tx_port_clock(txClk), .rxOut,
    .tx_frame_enable(txEn), .txNibbleIn(txNib), .tx_stream_error(txErr), .rxIn, .rxInReady,
    .txOut, .txOutValid, .txOutReady, .repCollision, .repReceiving,
    .segment_collision(col), .port_carrier_sense(crs), .speed100);
  rmmp_mac_model u_mac (.clk, .tx_port_clock(txClk), .rx_port_clock(rxClk), .rxOut,
    .tx_frame_enable(txEn), .txNibbleIn(txNib), .tx_stream_error(txErr));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // an error flag only turns into a bad symbol at 100 Mbps
  function automatic rmmp_pkg::rmmp_tx_t expTx(input rmmp_pkg::rmmp_tx_t v, input logic spd);
    if (spd && v.error) return {rmmp_pkg::BAD_SYMBOL_NIBBLE, 1'b1};
    return {v.nibble, 1'b0};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================================
  // core side stimulus and scoreboards; receiver stalls now and then
  always @(posedge clk) begin
    seed = xs(seed);
    txOutReady <= seed[0] | seed[1];
    repCollision <= seed[7];
    repReceiving <= rxLeft > 0;
    // a nibble that nobody sent means something was captured with enable low
    if (txOutValid && txOutReady) begin
      if (txExp.size() > 0) check(txOut, expTx(txExp.pop_front(), speed100));
      else check(txOutValid, 1'b0);
    end
    if (!rxInReady) sawFull = 1'b1;
    if (rxIn.valid && rxInReady) rxExp.push_back(rxIn);
    if (!rxIn.valid || rxInReady) begin
      rxIn <= (rxLeft > 0) ? {seed[11:8], 1'b1, seed[12]} : '0;
      if (rxLeft > 0) rxLeft--;
    end
    while (u_mac.rxQ.size() > 0 && rxExp.size() > 0)
      check(u_mac.rxQ.pop_front(), rxExp.pop_front());
  end
  // wire checks where outputs are settled
  always @(negedge clk) begin
    // the collision copy is only meaningful once a full cycle out of reset has passed
    if (armed) check(col, colLast);
    armed = arst_n;
    colLast = repCollision;
    if (rxOut !== rxPrev) check(clkPrev && !rxClk, 1'b1);
    check(txClk, rxClk);
    rxPrev = rxOut;
    clkPrev = rxClk;
  end
  task automatic traffic(input int n);
    rmmp_pkg::rmmp_tx_t t;
    logic done;
    done = 1'b0;
    rxLeft = n;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      t = {seed[3:0], seed[4]};
      u_mac.txQ.push_back(t);
      txExp.push_back(t);
    end
    repeat (40) @(negedge clk);
    check(crs, 1'b1);
    for (int i = 0; i < n * 300 && !done; i++) begin
      @(negedge clk);
      done = rxLeft == 0 && !rxIn.valid && rxExp.size() == 0 && txExp.size() == 0;
    end
    if (!done) begin
      errors++;
      test_done();
    end
    repeat (150) @(negedge clk);
    check(crs, 1'b0);
    check(8'(u_mac.rxQ.size()), 8'h0);
    check(sawFull, 1'b1);
  endtask
  // rising edges of the port clock seen in a fixed window
  task automatic countEdges(output int c);
    logic p;
    c = 0;
    p = rxClk;
    repeat (2000) begin
      @(negedge clk);
      if (rxClk && !p) c++;
      p = rxClk;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (20) @(negedge clk);
    check(speed100, 1'b1);
    countEdges(cnt[1]);
    traffic(16);
    $display("test fast traffic done");
    @(posedge clk) strap <= 1'b0;
    repeat (20) @(negedge clk);
    check(speed100, 1'b1);
    @(posedge clk) swReset <= 1'b1;
    @(posedge clk) swReset <= 1'b0;
    repeat (20) @(negedge clk);
    check(speed100, 1'b0);
    countEdges(cnt[0]);
    check(cnt[0] > 0 && cnt[1] >= 9 * cnt[0] && cnt[1] <= 11 * cnt[0], 1'b1);
    traffic(8);
    $display("test slow traffic done");
    test_done();
  end
endmodule // testbench
